// *** verilog/sdc_top.sv ***
// serial converter input control: shift, input and output registers
`default_nettype none
// Contract
// - A transfer is one 16-bit code, most significant bit first.
// - Each shift edge takes one serial_in bit into the shift register.
// - The shift clock is chip select OR serial clock; its rise shifts once.
// - The shift register holds unless that combined clock rises.
// - While input_latch_n is low the input register follows the shift register.
// - A dac_update rise with select, reset and latch high loads the output register.
// - The converter code changes only on that update edge or on a reset rise.
// - New serial data never disturbs the output register.
// - A reset rise presets both registers regardless of other inputs.
// - The preset is 8000h with reset_value_select high, else 0000h.
// - A reset rise leaves the shift register unchanged.
// - serial_out is driven from the shift register's top bit.
// - The output code is straight binary over a span of 65536.
module sdc_top #(
    parameter int WORD_BITS = sdc_pkg::SDC_WORD_BITS
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 chip_select_n_i,
    input  wire logic                 serial_clk_i,
    input  wire logic                 serial_in_i,
    input  wire logic                 input_latch_n_i,
    input  wire logic                 dac_update_i,
    input  wire logic                 preset_i,
    input  wire logic                 reset_value_select_i,
    output logic                      serial_out_o,
    output sdc_pkg::sdc_word_type     input_code_o,
    output sdc_pkg::sdc_word_type     dac_code_o,
    output logic                      dac_loaded_o
);
    import sdc_pkg::*;

    sdc_pins_if pins ();

    sdc_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .pins_i    ({reset_value_select_i, preset_i, dac_update_i, input_latch_n_i,
                     serial_in_i, serial_clk_i, chip_select_n_i}),
        .pins      (pins)
    );

    sdc_word_type shift_r;
    sdc_word_type shift_nxt;
    sdc_word_type inreg_r;
    sdc_word_type inreg_nxt;
    sdc_word_type dacreg_r;
    sdc_word_type dacreg_nxt;
    logic         comb_clk_r;
    logic         comb_clk_nxt;
    logic         upd_prev_r;
    logic         upd_prev_nxt;
    logic         rst_prev_r;
    logic         rst_prev_nxt;
    logic         loaded_r;
    logic         loaded_nxt;
    logic         comb_clk;
    logic         shift_edge;
    logic         upd_edge;
    logic         rst_edge;
    sdc_word_type preset_code;

    assign comb_clk    = pins.sel_n | pins.sclk;
    assign shift_edge  = comb_clk & ~comb_clk_r;
    assign upd_edge    = pins.update & ~upd_prev_r;
    assign rst_edge    = pins.rst & ~rst_prev_r;
    assign preset_code = pins.rsel ? SDC_CODE_MID : SDC_CODE_ZERO;

    // edge history
    // preset pin idles high, so its history starts high: no false preset
    always_comb begin
        comb_clk_nxt = comb_clk;
        upd_prev_nxt = pins.update;
        rst_prev_nxt = pins.rst;
        if (reset_i) begin
            comb_clk_nxt = 1'b1;
            upd_prev_nxt = 1'b0;
            rst_prev_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        comb_clk_r <= comb_clk_nxt;
        upd_prev_r <= upd_prev_nxt;
        rst_prev_r <= rst_prev_nxt;
    end

    // shift register, msb first, untouched by the preset
    always_comb begin
        shift_nxt = shift_r;
        if (shift_edge) begin
            shift_nxt = {shift_r[WORD_BITS-2:0], pins.sdata};
        end
        if (reset_i) begin
            shift_nxt = SDC_SHIFT_INIT;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        shift_r <= shift_nxt;
    end

    // input and output registers; preset has top priority
    always_comb begin
        inreg_nxt  = inreg_r;
        dacreg_nxt = dacreg_r;
        loaded_nxt = 1'b0;
        if (rst_edge) begin
            inreg_nxt  = preset_code;
            dacreg_nxt = preset_code;
        end else begin
            if (!pins.latch_n) begin
                inreg_nxt = shift_r;
            end
            if (upd_edge && pins.sel_n && pins.rst && pins.latch_n) begin
                dacreg_nxt = inreg_r;
                loaded_nxt = 1'b1;
            end
        end
        if (reset_i) begin
            inreg_nxt  = SDC_CODE_ZERO;
            dacreg_nxt = SDC_CODE_ZERO;
            loaded_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        inreg_r  <= inreg_nxt;
        dacreg_r <= dacreg_nxt;
        loaded_r <= loaded_nxt;
    end

    assign serial_out_o = shift_r[WORD_BITS-1];
    assign input_code_o = inreg_r;
    assign dac_code_o   = dacreg_r;
    assign dac_loaded_o = loaded_r;

    a_shift_moves: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        shift_edge |=> shift_r == {$past(shift_r[WORD_BITS-2:0]), $past(pins.sdata)})
        else $error("shift register did not take serial bit");
    a_shift_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !shift_edge |=> $stable(shift_r))
        else $error("shift register moved without edge");
    a_preset_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rst_edge |=> (dacreg_r == ($past(pins.rsel) ? 16'h8000 : 16'h0000))
                     && inreg_r == dacreg_r)
        else $error("wrong preset code");
    a_preset_shift: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rst_edge && !shift_edge) |=> $stable(shift_r))
        else $error("preset disturbed shift register");
    a_latch_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!pins.latch_n && !rst_edge) |=> inreg_r == $past(shift_r))
        else $error("input register not following");
    a_update_load: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (upd_edge && pins.sel_n && pins.rst && pins.latch_n && !rst_edge)
        |=> dacreg_r == $past(inreg_r) && dac_loaded_o)
        else $error("update edge did not load");
    a_output_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!upd_edge && !rst_edge) |=> $stable(dacreg_r))
        else $error("output code changed without update");
    a_chain_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        shift_edge |=> serial_out_o == $past(shift_r[WORD_BITS-2]))
        else $error("serial_out not top bit");
    a_loaded_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dac_loaded_o |=> !dac_loaded_o)
        else $error("load pulse too long");

    // refusals, holds and priorities
    a_update_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (upd_edge && !(pins.sel_n && pins.rst && pins.latch_n) && !rst_edge)
        |=> $stable(dacreg_r) && !dac_loaded_o)
        else $error("refused update changed output register");
    a_latch_keeps_dac: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!pins.latch_n && !upd_edge && !rst_edge)
        |=> $stable(dacreg_r))
        else $error("latch disturbed output register");
    a_serial_no_disturb: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (shift_edge && !upd_edge && !rst_edge)
        |=> $stable(dacreg_r))
        else $error("shifting disturbed output register");
    a_inreg_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (pins.latch_n && !rst_edge)
        |=> $stable(inreg_r))
        else $error("input register moved while latch high");
    a_preset_no_load: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rst_edge
        |=> !dac_loaded_o)
        else $error("preset flagged as update load");
    a_preset_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rst_edge && !pins.latch_n)
        |=> inreg_r == dacreg_r && !dac_loaded_o)
        else $error("latch overrode preset");
    a_loaded_cause: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dac_loaded_o
        |-> $past(upd_edge))
        else $error("load flag without update edge");
    a_dac_matches_input: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        dac_loaded_o
        |-> dac_code_o == $past(inreg_r))
        else $error("output register not loaded from input register");
    a_chain_holds: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !shift_edge
        |=> $stable(serial_out_o))
        else $error("serial_out moved without shift edge");
    a_msb_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        shift_edge
        |=> shift_r[0] == $past(pins.sdata))
        else $error("new bit not at the low end");

    c_shift: cover property (@(posedge ref_clk_i) disable iff (reset_i) shift_edge);
    c_latch: cover property (@(posedge ref_clk_i) disable iff (reset_i) !pins.latch_n);
    c_update: cover property (@(posedge ref_clk_i) disable iff (reset_i) dac_loaded_o);
    c_mid: cover property (@(posedge ref_clk_i) disable iff (reset_i) rst_edge && pins.rsel);
    c_refused: cover property (@(posedge ref_clk_i) disable iff (reset_i) upd_edge && !pins.latch_n);
endmodule : sdc_top
`default_nettype wire

// *** verilog/sdc_pkg.sv ***
// shared constants for the serial converter input control
`default_nettype none
package sdc_pkg;
    localparam int              SDC_WORD_BITS  = 16;
    localparam logic [15:0]     SDC_CODE_MID   = 16'h8000;
    localparam logic [15:0]     SDC_CODE_ZERO  = 16'h0000;
    localparam logic [15:0]     SDC_SHIFT_INIT = 16'h0000;
    localparam int              SDC_SYNC_STAGES = 2;
    localparam int              SDC_CODE_SPAN  = 65536;
    typedef logic [SDC_WORD_BITS-1:0] sdc_word_type;
endpackage : sdc_pkg
`default_nettype wire

// *** verilog/sdc_pins_if.sv ***
// synchronised pin levels passed from the front end to the core
`default_nettype none
interface sdc_pins_if;
    logic sel_n;
    logic sclk;
    logic sdata;
    logic latch_n;
    logic update;
    logic rst;
    logic rsel;
    modport src (output sel_n, sclk, sdata, latch_n, update, rst, rsel);
    modport dst (input  sel_n, sclk, sdata, latch_n, update, rst, rsel);
endinterface : sdc_pins_if
`default_nettype wire

// *** verilog/sdc_sync.sv ***
// two-stage synchroniser bank for the converter pins
`default_nettype none
module sdc_sync (
    input  wire logic  ref_clk_i,
    input  wire logic  reset_i,
    input  wire logic  [6:0] pins_i,
    sdc_pins_if.src    pins
);
    logic [6:0] stage1_r;
    logic [6:0] stage2_r;
    logic [6:0] stage1_nxt;
    logic [6:0] stage2_nxt;

    // idle levels: deselected, clock high, latch and preset high, update low
    always_comb begin
        stage1_nxt = pins_i;
        stage2_nxt = stage1_r;
        if (reset_i) begin
            stage1_nxt = 7'h2B;
            stage2_nxt = 7'h2B;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        stage1_r <= stage1_nxt;
        stage2_r <= stage2_nxt;
    end

    assign pins.sel_n   = stage2_r[0];
    assign pins.sclk    = stage2_r[1];
    assign pins.sdata   = stage2_r[2];
    assign pins.latch_n = stage2_r[3];
    assign pins.update  = stage2_r[4];
    assign pins.rst     = stage2_r[5];
    assign pins.rsel    = stage2_r[6];
endmodule : sdc_sync
`default_nettype wire

// *** test/sdc_host_model.sv ***
// host model driving the converter pins
`default_nettype none
module sdc_host_model (
    output var logic chip_select_n_o,
    output var logic serial_clk_o,
    output var logic serial_in_o,
    output var logic input_latch_n_o,
    output var logic dac_update_o,
    output var logic preset_o,
    output var logic reset_value_select_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {chip_select_n_o, serial_clk_o, input_latch_n_o} = 3'h7;
        // preset idles high: update needs it high, its rise presets
        {serial_in_o, dac_update_o, preset_o, reset_value_select_o} = 4'h2;
    end
    // top n bits msb first; late_cs raises select with clock low
    task automatic send_bits(input logic [15:0] w, input int n, input bit late_cs);
        chip_select_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_clk_o = 1'b0;
            serial_in_o = w[i];
            #62.5 serial_clk_o = 1'b1;
            #62.5;
        end
        if (late_cs) begin
            serial_clk_o = 1'b0;
            #62.5;
        end
        chip_select_n_o = 1'b1;
        #62.5 serial_in_o = ~serial_in_o;
        serial_clk_o = 1'b1;
    endtask
    task automatic pulse_latch();
        input_latch_n_o = 1'b0;
        #100 input_latch_n_o = 1'b1;
        #100;
    endtask
    task automatic pulse_update();
        dac_update_o = 1'b1;
        #200 dac_update_o = 1'b0;
        #200;
    endtask
    task automatic pulse_preset(input logic sel);
        reset_value_select_o = sel;
        #20 preset_o = 1'b0;
        #150 preset_o = 1'b1;
        #100;
    endtask
endmodule // sdc_host_model
`default_nettype wire

// *** test/sdc_top_tb.sv ***
// self-checking bench for the serial converter input control
`default_nettype none
module sdc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sdc_pkg::*;
    logic         ref_clk_i;
    logic         reset_i;
    wire logic    cs_n, sclk, serial_in, latch_n, upd, pre, rsel;
    logic         serial_out_o;
    logic         dac_loaded_o;
    sdc_word_type input_code_o;
    sdc_word_type dac_code_o;
    int           bad_count = 0;
    int           cmp_count = 0;
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    sdc_top DUT (.ref_clk_i, .reset_i, .chip_select_n_i(cs_n), .serial_clk_i(sclk),
        .serial_in_i(serial_in), .input_latch_n_i(latch_n), .dac_update_i(upd), .preset_i(pre),
        .reset_value_select_i(rsel), .serial_out_o, .input_code_o, .dac_code_o,
        .dac_loaded_o);
    sdc_host_model host (.chip_select_n_o(cs_n), .serial_clk_o(sclk), .serial_in_o(serial_in),
        .input_latch_n_o(latch_n), .dac_update_o(upd), .preset_o(pre),
        .reset_value_select_o(rsel));
    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input sdc_word_type exp, input sdc_word_type got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wait_loaded();
        for (int n = 0; n < 60 && dac_loaded_o !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (dac_loaded_o !== 1'b1) begin
            check("dac_loaded", 16'h0001, {15'h0000, dac_loaded_o});
            conclude();
        end
    endtask
    task automatic t_preset(input logic sel, input sdc_word_type exp);
        host.pulse_preset(sel);
        settle();
        check("input_code", exp, input_code_o);
        check("dac_code", exp, dac_code_o);
    endtask
    task automatic t_write_update();
        host.send_bits(16'hA5C3, 16, 1'b0);
        settle();
        check("dac_code", 16'h8000, dac_code_o);
        check("serial_out", 16'h0001, {15'h0000, serial_out_o});
        host.pulse_latch();
        settle();
        check("input_code", 16'hA5C3, input_code_o);
        check("dac_code", 16'h8000, dac_code_o);
        fork
            host.pulse_update();
            wait_loaded();
        join
        settle();
        check("dac_code", 16'hA5C3, dac_code_o);
    endtask
    task automatic t_refused_update();
        host.send_bits(16'h1234, 16, 1'b0);
        fork
            host.pulse_latch();
            #20 host.pulse_update();
        join
        settle();
        check("input_code", 16'h1234, input_code_o);
        check("dac_code", 16'hA5C3, dac_code_o);
    endtask
    task automatic t_preset_in_latch();
        fork
            host.pulse_preset(1'b1);
            #100 host.pulse_latch();
        join
        settle();
        check("dac_code", 16'h8000, dac_code_o);
        check("input_code", 16'h1234, input_code_o);
    endtask
    task automatic t_preset_keeps_shift();
        host.send_bits(16'h4000, 16, 1'b0);
        t_preset(1'b0, 16'h0000);
        check("serial_out", 16'h0000, {15'h0000, serial_out_o});
        host.send_bits(16'hFFFF, 1, 1'b0);
        settle();
        check("serial_out", 16'h0001, {15'h0000, serial_out_o});
        host.pulse_latch();
        settle();
        check("input_code", 16'h8001, input_code_o);
    endtask
    task automatic t_late_select();
        host.send_bits(16'h00F1, 16, 1'b1);
        host.pulse_latch();
        settle();
        check("input_code", 16'h01E3, input_code_o);
    endtask
    initial begin
        reset_i = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        #1 reset_i = 1'b0;
        settle();
        t_preset(1'b0, 16'h0000);
        t_preset(1'b1, 16'h8000);
        t_write_update();
        t_refused_update();
        t_preset_in_latch();
        t_preset_keeps_shift();
        t_late_select();
        conclude();
    end
endmodule // sdc_top_tb
`default_nettype wire
